// ===== osw_consts.svh
`ifndef OSW_CONSTS_SVH
`define OSW_CONSTS_SVH

// word layout
`define OSW_WORD_BITS     16
`define OSW_NUM_OUT       8
`define OSW_OL_LSB        8
`define OSW_OUT5_BIT      4
`define OSW_OUT6_BIT      5
`define OSW_STAT_PAD      8'h00

// device pin synchroniser: chip select resets high, all else low
`define OSW_SYNC_W        16
`define OSW_SYNC_RST      16'h8000

// timing
`define OSW_CLK_KHZ       40000
`define OSW_GAP_US        300
`define OSW_GAP_CYC       ((`OSW_GAP_US * `OSW_CLK_KHZ) / 1000 + 1)
`define OSW_PWM_MAX_HZ    2000
`define OSW_PWM_HALF_CYC  ((`OSW_CLK_KHZ * 1000 + 2 * `OSW_PWM_MAX_HZ - 1) / (2 * `OSW_PWM_MAX_HZ))
`define OSW_SCLK_HALF     10
`define OSW_SCLK_HALF_MIN 8
`define OSW_CNT_W         16

// controller registers
`define OSW_REG_CMD       4'h0
`define OSW_REG_RX        4'h4
`define OSW_REG_STAT      4'h8
`define OSW_REG_DRV       4'hc
`define OSW_STAT_BUSY     0
`define OSW_STAT_DONE     1
`define OSW_DRV_MODE5     0
`define OSW_DRV_MODE6     1
`define OSW_DRV_LVL5      2
`define OSW_DRV_LVL6      3
`define OSW_DRV_EN        4
`define OSW_DRV_RST       5'h00

`endif

// ===== osw_pkg.sv
package osw_pkg;
  typedef logic [15:0] osw_word_t;
  typedef enum logic [2:0] {
    st_idle,
    st_lead,
    st_high,
    st_low,
    st_lag,
    st_gap
  } osw_host_state_t;
endpackage

// ===== osw_spi_if.sv
`timescale 1ns/100ps
interface osw_spi_if;
  logic cs_n;
  logic sclk;
  logic serial_cmd_in;
  logic status_out;
  logic status_out_oe;
  logic enable;
  logic direct_drive_five;
  logic direct_drive_six;
  wire  status_line;

  // released line shows the inverse, so a sample taken too late is caught
  assign status_line = status_out_oe ? status_out : !status_out;

  modport dev (
    input  cs_n,
    input  sclk,
    input  serial_cmd_in,
    input  enable,
    input  direct_drive_five,
    input  direct_drive_six,
    output status_out,
    output status_out_oe
  );

  modport host (
    output cs_n,
    output sclk,
    output serial_cmd_in,
    output enable,
    output direct_drive_five,
    output direct_drive_six,
    input  status_line
  );
endinterface

// ===== osw_device.sv
`timescale 1ns/100ps
`include "osw_consts.svh"
module osw_device (
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  osw_spi_if.dev                          link,
  input  wire logic                       logic_supply_ok,
  input  wire logic                       battery_supply_ok,
  input  wire logic [`OSW_NUM_OUT-1:0]    fault_in,
  output logic      [`OSW_NUM_OUT-1:0]    out_drive,
  output logic      [`OSW_NUM_OUT-1:0]    ol_current_en,
  output logic                            sleep_state
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [`OSW_SYNC_W-1:0] pin_raw;
  logic [`OSW_SYNC_W-1:0] sync1_ff;
  logic [`OSW_SYNC_W-1:0] sync2_ff;

  assign pin_raw = {link.cs_n,
                    link.sclk,
                    link.serial_cmd_in,
                    link.enable,
                    logic_supply_ok,
                    battery_supply_ok,
                    link.direct_drive_five,
                    link.direct_drive_six,
                    fault_in};

  // reset values hold chip select high and all else low; the supply-good pins idle high, so their edge after reset is a power-on event
  localparam logic [`OSW_SYNC_W-1:0] SYNC_RST_C = `OSW_SYNC_RST;

  genvar gi;
  generate
    for (gi = 0; gi < `OSW_SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (!resetn) begin
          sync1_ff[gi] <= SYNC_RST_C[gi];
          sync2_ff[gi] <= SYNC_RST_C[gi];
        end else begin
          sync1_ff[gi] <= pin_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate

  logic                    cs_n_s;
  logic                    sclk_s;
  logic                    din_s;
  logic                    en_s;
  logic                    vdd_s;
  logic                    vbat_s;
  logic                    dd5_s;
  logic                    dd6_s;
  logic [`OSW_NUM_OUT-1:0] fault_s;

  assign cs_n_s  = sync2_ff[15];
  assign sclk_s  = sync2_ff[14];
  assign din_s   = sync2_ff[13];
  assign en_s    = sync2_ff[12];
  assign vdd_s   = sync2_ff[11];
  assign vbat_s  = sync2_ff[10];
  assign dd5_s   = sync2_ff[9];
  assign dd6_s   = sync2_ff[8];
  assign fault_s = sync2_ff[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // edge detection

  logic cs_n_d_ff;
  logic sclk_d_ff;
  logic en_d_ff;
  logic vdd_d_ff;
  logic vbat_d_ff;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cs_n_d_ff <= 1'b1;
      sclk_d_ff <= 1'b0;
      en_d_ff   <= 1'b0;
      vdd_d_ff  <= 1'b0;
      vbat_d_ff <= 1'b0;
    end else begin
      cs_n_d_ff <= cs_n_s;
      sclk_d_ff <= sclk_s;
      en_d_ff   <= en_s;
      vdd_d_ff  <= vdd_s;
      vbat_d_ff <= vbat_s;
    end
  end

  logic selected;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic sclk_rise;
  logic por;

  // clock edges count only while selected; the master keeps sclk low at
  // select edges, so no edge is lost or invented at the boundary
  assign selected  = !cs_n_s && !cs_n_d_ff;
  assign cs_fall   = !cs_n_s && cs_n_d_ff;
  assign cs_rise   = cs_n_s && !cs_n_d_ff;
  assign sclk_fall = selected && !sclk_s && sclk_d_ff;
  assign sclk_rise = selected && sclk_s && !sclk_d_ff;

  // sleep and every power-on event hold the logic in its reset state
  assign por = !resetn || !en_s || !vdd_s || !vbat_s
               || (en_s && !en_d_ff)
               || (vdd_s && !vdd_d_ff) || (vbat_s && !vbat_d_ff);

  ////////////////////////////////////////////////////////////////////////////
  // shift register and serial output

  logic [`OSW_WORD_BITS-1:0] shift_ff;
  logic [`OSW_WORD_BITS-1:0] cmd_ff;
  logic [`OSW_NUM_OUT-1:0]   status;
  logic                      dout_ff;

  // snapshot at select fall: a fault arising mid-frame waits for the next word
  // off outputs only report when their load current is enabled
  assign status = fault_s & (cmd_ff[`OSW_NUM_OUT-1:0]
                  | cmd_ff[`OSW_WORD_BITS-1:`OSW_OL_LSB]);

  always_ff @(posedge clk_sys) begin
    if (por) begin
      shift_ff <= '0;
    end else if (cs_fall) begin
      shift_ff <= {`OSW_STAT_PAD, status};
    end else if (sclk_fall) begin
      shift_ff <= {shift_ff[`OSW_WORD_BITS-2:0], din_s};
    end
  end

  // one register for both words: longer chains simply pass through
  always_ff @(posedge clk_sys) begin
    if (por) begin
      dout_ff <= 1'b0;
    end else if (cs_fall) begin
      dout_ff <= 1'b0;
    end else if (sclk_rise) begin
      dout_ff <= shift_ff[`OSW_WORD_BITS-1];
    end
  end

  assign link.status_out    = dout_ff;
  assign link.status_out_oe = !cs_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // command latch and output drive

  // no bit counter: whatever the register holds at select rising is taken
  always_ff @(posedge clk_sys) begin
    if (por) begin
      cmd_ff <= '0;
    end else if (cs_rise) begin
      cmd_ff <= shift_ff;
    end
  end

  logic [`OSW_NUM_OUT-1:0] direct_mask;

  always_comb begin
    direct_mask                = '0;
    direct_mask[`OSW_OUT5_BIT] = dd5_s;
    direct_mask[`OSW_OUT6_BIT] = dd6_s;
  end

  // drive settles one cycle after the latch; sleep or a power event wins
  always_ff @(posedge clk_sys) begin
    if (por) begin
      out_drive     <= '0;
      ol_current_en <= '0;
      sleep_state   <= 1'b1;
    end else begin
      out_drive     <= cmd_ff[`OSW_NUM_OUT-1:0] | direct_mask;
      ol_current_en <= cmd_ff[`OSW_WORD_BITS-1:`OSW_OL_LSB];
      sleep_state   <= 1'b0;
    end
  end

endmodule

// ===== osw_host.sv
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "osw_consts.svh"
module osw_host #(
  parameter int SCLK_HALF  = `OSW_SCLK_HALF,
  parameter int GAP_CYC    = `OSW_GAP_CYC,
  parameter int PWM_HALF   = `OSW_PWM_HALF_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  osw_spi_if.host          link,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);

  if (SCLK_HALF < `OSW_SCLK_HALF_MIN || SCLK_HALF >= (1 << `OSW_CNT_W)
      || GAP_CYC < 1 || GAP_CYC >= (1 << `OSW_CNT_W)
      || PWM_HALF < 1 || PWM_HALF >= (1 << `OSW_CNT_W)) begin : g_bad_param
    $error("osw_host: timing parameter out of range");
  end

  localparam logic [`OSW_CNT_W-1:0] HALF_C = SCLK_HALF[`OSW_CNT_W-1:0];
  localparam logic [`OSW_CNT_W-1:0] GAP_C  = GAP_CYC[`OSW_CNT_W-1:0];
  localparam logic [`OSW_CNT_W-1:0] PWM_C  = PWM_HALF[`OSW_CNT_W-1:0];
  localparam logic [4:0]            BITS_C = 5'(`OSW_WORD_BITS);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  osw_pkg::osw_word_t cmd_ff;
  osw_pkg::osw_word_t rx_ff;
  logic [4:0]         drv_ff;
  logic               done_ff;
  logic               start;
  logic               finish;
  logic               busy;

  assign start = reg_wr && reg_addr == `OSW_REG_CMD && !busy;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cmd_ff <= '0;
      drv_ff <= `OSW_DRV_RST;
    end else begin
      if (start) begin
        cmd_ff <= reg_wdata[15:0];
      end
      if (reg_wr && reg_addr == `OSW_REG_DRV) begin
        drv_ff <= reg_wdata[4:0];
      end
    end
  end

  // a finishing transfer wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      done_ff <= 1'b0;
    end else if (finish) begin
      done_ff <= 1'b1;
    end else if (reg_wr && reg_addr == `OSW_REG_STAT && reg_wdata[`OSW_STAT_DONE]) begin
      done_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `OSW_REG_CMD:  reg_rdata <= {16'h0000, cmd_ff};
        `OSW_REG_RX:   reg_rdata <= {16'h0000, rx_ff};
        `OSW_REG_STAT: reg_rdata <= {30'h00000000, done_ff, busy};
        `OSW_REG_DRV:  reg_rdata <= {27'h0000000, drv_ff};
        default:       reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial engine

  osw_pkg::osw_host_state_t state_ff;
  logic [`OSW_CNT_W-1:0]    cnt_ff;
  logic [4:0]               bits_ff;
  osw_pkg::osw_word_t       tx_ff;
  osw_pkg::osw_word_t       rxs_ff;
  logic                     miso1_ff;
  logic                     miso2_ff;
  logic                     cnt_zero;
  osw_pkg::osw_word_t       cmd_masked;

  assign busy     = state_ff != osw_pkg::st_idle;
  assign cnt_zero = cnt_ff == '0;
  assign finish   = state_ff == osw_pkg::st_gap && cnt_zero;

  // a modulated output keeps its serial bit at zero
  always_comb begin
    cmd_masked                = reg_wdata[15:0];
    cmd_masked[`OSW_OUT5_BIT] = reg_wdata[`OSW_OUT5_BIT] && !drv_ff[`OSW_DRV_MODE5];
    cmd_masked[`OSW_OUT6_BIT] = reg_wdata[`OSW_OUT6_BIT] && !drv_ff[`OSW_DRV_MODE6];
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      miso1_ff <= 1'b0;
      miso2_ff <= 1'b0;
    end else begin
      miso1_ff <= link.status_line;
      miso2_ff <= miso1_ff;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_ff <= osw_pkg::st_idle;
      cnt_ff   <= '0;
      bits_ff  <= '0;
      tx_ff    <= '0;
      rxs_ff   <= '0;
      rx_ff    <= '0;
    end else begin
      cnt_ff <= cnt_zero ? '0 : cnt_ff - 1'b1;
      case (state_ff)
        osw_pkg::st_idle: begin
          if (start) begin
            tx_ff    <= cmd_masked;
            bits_ff  <= '0;
            cnt_ff   <= HALF_C;
            state_ff <= osw_pkg::st_lead;
          end
        end
        osw_pkg::st_lead: begin
          if (cnt_zero) begin
            cnt_ff   <= HALF_C;
            state_ff <= osw_pkg::st_high;
          end
        end
        osw_pkg::st_high: begin
          if (cnt_zero) begin
            rxs_ff   <= {rxs_ff[14:0], miso2_ff};
            bits_ff  <= bits_ff + 5'h01;
            cnt_ff   <= HALF_C;
            state_ff <= osw_pkg::st_low;
          end
        end
        osw_pkg::st_low: begin
          // data moves on the rising edge, well clear of the sampling edge
          if (cnt_zero) begin
            cnt_ff <= HALF_C;
            if (bits_ff == BITS_C) begin
              state_ff <= osw_pkg::st_lag;
            end else begin
              tx_ff    <= {tx_ff[14:0], 1'b0};
              state_ff <= osw_pkg::st_high;
            end
          end
        end
        osw_pkg::st_lag: begin
          if (cnt_zero) begin
            rx_ff    <= rxs_ff;
            cnt_ff   <= GAP_C;
            state_ff <= osw_pkg::st_gap;
          end
        end
        osw_pkg::st_gap: begin
          // spacing lets the device sense faults before the next word
          if (cnt_zero) begin
            state_ff <= osw_pkg::st_idle;
          end
        end
        default: begin
          state_ff <= osw_pkg::st_idle;
        end
      endcase
    end
  end

  assign link.cs_n          = !(state_ff == osw_pkg::st_lead || state_ff == osw_pkg::st_high
                                || state_ff == osw_pkg::st_low || state_ff == osw_pkg::st_lag);
  assign link.sclk          = state_ff == osw_pkg::st_high;
  assign link.serial_cmd_in = tx_ff[`OSW_WORD_BITS-1];
  assign link.enable        = drv_ff[`OSW_DRV_EN];

  ////////////////////////////////////////////////////////////////////////////
  // direct drive with rate limit

  logic [1:0] dd_ff;
  logic [1:0] mode;
  logic [1:0] lvl;

  assign mode = {drv_ff[`OSW_DRV_MODE6], drv_ff[`OSW_DRV_MODE5]};
  assign lvl  = {drv_ff[`OSW_DRV_LVL6], drv_ff[`OSW_DRV_LVL5]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dd
      logic [`OSW_CNT_W-1:0] hold_ff;
      // a level request arriving early waits; only reset or clearing the mode drops the output at once, with no hold
      always_ff @(posedge clk_sys) begin
        if (!resetn || !mode[gi]) begin
          dd_ff[gi] <= 1'b0;
          hold_ff   <= '0;
        end else if (hold_ff != '0) begin
          hold_ff <= hold_ff - 1'b1;
        end else if (dd_ff[gi] != lvl[gi]) begin
          dd_ff[gi] <= lvl[gi];
          hold_ff   <= PWM_C;
        end
      end
    end
  endgenerate

  assign link.direct_drive_five = dd_ff[0];
  assign link.direct_drive_six  = dd_ff[1];

endmodule

// ===== osw_device_note_end.sv
`timescale 1ns/100ps

// ===== osw_spi_sva.sv
`timescale 1ns/100ps
module osw_spi_sva (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_cmd_in,
  input wire logic status_out,
  input wire logic status_out_oe,
  input wire logic direct_drive_five,
  input wire logic direct_drive_six
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  logic       sclk_ff;
  logic [4:0] nfall_ff;
  logic [4:0] nrise_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // edge counts within one frame
  always_ff @(posedge clk_sys) begin
    sclk_ff <= sclk;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn || cs_n) begin
      nfall_ff <= 5'h00;
      nrise_ff <= 5'h00;
    end else begin
      if (sclk_ff && !sclk) nfall_ff <= nfall_ff + 5'h01;
      if (!sclk_ff && sclk) nrise_ff <= nrise_ff + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_sclk_cs_edge: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
    else $error("serial clock high at a select edge");
  a_sclk_parked: assert property (cs_n |-> !sclk)
    else $error("serial clock not parked low while deselected");
  a_oe_follows_cs: assert property (status_out_oe == !$past(cs_n, 2))
    else $error("output enable does not track select");
  a_status_lead: assert property ($fell(cs_n) |-> ##3 !status_out [*8])
    else $error("status line not loaded low at select fall");
  a_first_byte_zero: assert property (!cs_n && $fell(sclk) && nrise_ff <= 5'h08 |-> !status_out)
    else $error("upper status byte not zero");
  a_status_hold: assert property ($fell(sclk) |-> $stable(status_out) [*4])
    else $error("status changed away from a rising clock");
  a_sixteen_falls: assert property ($rose(cs_n) |-> nfall_ff == 5'h10)
    else $error("frame did not carry sixteen falling edges");
  a_data_hold: assert property ($rose(sclk) |=> $stable(serial_cmd_in) [*8])
    else $error("serial data moved while clock high");
  a_pwm_five: assert property ($changed(direct_drive_five) |=> $stable(direct_drive_five) [*5])
    else $error("direct drive five toggled too fast");
  a_pwm_six: assert property ($changed(direct_drive_six) |=> $stable(direct_drive_six) [*5])
    else $error("direct drive six toggled too fast");

  c_full_frame: cover property ($rose(cs_n) && nfall_ff == 5'h10);
  c_fault_seen: cover property ($fell(sclk) && status_out);
  c_direct_five: cover property ($rose(direct_drive_five));
endmodule

// ===== tb_octal_switch_spi_control.sv
`timescale 1ns/100ps
module tb_octal_switch_spi_control;
  logic              clk_sys;
  logic              resetn;
  logic [3:0]        reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_wr;
  logic              reg_rd;
  logic [31:0]       reg_rdata;
  logic              logic_supply_ok;
  logic              battery_supply_ok;
  logic [7:0]        fault_in;
  logic [7:0]        out_drive;
  logic [7:0]        ol_current_en;
  logic              sleep_state;
  int                err_total;
  int                check_count;
  osw_pkg::osw_word_t cur_cmd;
  logic [31:0]       rd_val;
  logic [4:0]        cur_drv;
  logic [15:0]       corner [4] = '{16'h00ff, 16'hff00, 16'h0000, 16'hffff};

  osw_spi_if link ();
  osw_host #(.SCLK_HALF(10), .GAP_CYC(20), .PWM_HALF(5)) u_osw_host (
    .clk_sys(clk_sys), .resetn(resetn), .link(link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  osw_device u_osw_device (
    .clk_sys(clk_sys), .resetn(resetn), .link(link), .logic_supply_ok(logic_supply_ok),
    .battery_supply_ok(battery_supply_ok), .fault_in(fault_in), .out_drive(out_drive),
    .ol_current_en(ol_current_en), .sleep_state(sleep_state));
  osw_spi_sva u_osw_spi_sva (
    .clk_sys(clk_sys), .resetn(resetn), .cs_n(link.cs_n), .sclk(link.sclk),
    .serial_cmd_in(link.serial_cmd_in), .status_out(link.status_out),
    .status_out_oe(link.status_out_oe), .direct_drive_five(link.direct_drive_five),
    .direct_drive_six(link.direct_drive_six));

  always #12.5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // word as sent: a modulated output's serial bit goes out as zero
  function automatic logic [15:0] exp_sent(input logic [15:0] c, input logic [4:0] d);
    exp_sent = c;
    if (d[0]) exp_sent[4] = 1'b0;
    if (d[1]) exp_sent[5] = 1'b0;
  endfunction

  function automatic logic [7:0] exp_out(input logic [15:0] c, input logic [4:0] d);
    exp_out    = c[7:0];
    exp_out[4] = c[4] | (d[0] & d[2]);
    exp_out[5] = c[5] | (d[1] & d[3]);
  endfunction

  function automatic logic [7:0] exp_stat(input logic [7:0] f, input logic [15:0] c);
    exp_stat = f & (c[7:0] | c[15:8]);
  endfunction

  // dup issues a second command while busy; the host must drop it
  task automatic xfer(input logic [15:0] cmd, input bit dup);
    logic [7:0]  exp_st;
    logic [15:0] sent;
    int          n;
    sent = exp_sent(cmd, cur_drv);
    wr(4'h0, {16'h0000, cmd});
    // fault pins were set by the edge before this write
    exp_st = exp_stat(fault_in, cur_cmd);
    if (dup) wr(4'h0, {16'h0000, ~cmd});
    n = 0;
    rd_val = 32'h0;
    while (rd_val[1] !== 1'b1 && n < 1000) begin
      rd(4'h8, rd_val);
      n++;
    end
    chk("stat", 16'h0002, {14'h0, rd_val[1:0]});
    rd(4'h4, rd_val);
    chk("rx", {8'h00, exp_st}, rd_val[15:0]);
    chk("out", {8'h00, exp_out(sent, cur_drv)}, {8'h00, out_drive});
    chk("ol", {8'h00, sent[15:8]}, {8'h00, ol_current_en});
    wr(4'h8, 32'h2);
    cur_cmd = sent;
  endtask

  task automatic chk_off(input string what);
    chk(what, 16'h0000, {out_drive, ol_current_en});
    cur_cmd = 16'h0000;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1250000;
    err_total++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h210ba418));
    clk_sys = 1'b0;
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    logic_supply_ok = 1'b1;
    battery_supply_ok = 1'b1;
    fault_in = 8'hff;
    cur_cmd = 16'h0000;
    cur_drv = 5'h00;
    err_total = 0;
    check_count = 0;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("sleep", 16'h0001, {15'h0, sleep_state});
    rd(4'h2, rd_val);
    chk("unmapped", 16'h0000, rd_val[15:0]);
    wr(4'hc, 32'h10);
    repeat (10) @(posedge clk_sys);
    chk("awake", 16'h0000, {15'h0, sleep_state});
    $display("test wake done");
    for (int i = 0; i < 14; i++) begin
      if (i >= 4) fault_in <= 8'($urandom);
      xfer(i < 4 ? corner[i] : 16'($urandom), i == 6);
    end
    $display("test transfers done");
    xfer(16'h0000, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wr(4'hc, 32'h10 | (32'h5 << i));
      repeat (20) @(posedge clk_sys);
      chk("direct on", 16'h0010 << i, {8'h00, out_drive});
      wr(4'hc, 32'h10 | (32'h1 << i));
      repeat (20) @(posedge clk_sys);
      chk("direct off", 16'h0000, {8'h00, out_drive});
      wr(4'hc, 32'h10);
    end
    wr(4'hc, 32'h11);
    cur_drv = 5'h11;
    repeat (20) @(posedge clk_sys);
    xfer(16'h0030, 1'b0);
    wr(4'hc, 32'h10);
    cur_drv = 5'h10;
    $display("test direct drive done");
    xfer(16'hffff, 1'b0);
    wr(4'hc, 32'h0);
    repeat (10) @(posedge clk_sys);
    chk_off("sleep outputs");
    chk("sleep flag", 16'h0001, {15'h0, sleep_state});
    wr(4'hc, 32'h10);
    repeat (10) @(posedge clk_sys);
    chk_off("enable por");
    for (int s = 0; s < 2; s++) begin
      xfer(16'hffff, 1'b0);
      if (s == 0) logic_supply_ok <= 1'b0;
      else battery_supply_ok <= 1'b0;
      repeat (4) @(posedge clk_sys);
      logic_supply_ok <= 1'b1;
      battery_supply_ok <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk_off("supply por");
    end
    xfer(16'h5a3c, 1'b0);
    $display("test power events done");
    print_verdict();
  end
endmodule
